// *** rtl/tpo_top.sv ***
// timing pulse output: mode registers, delayed second tick, output drivers
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps

// Summary of operation
// - the coaxial output offers off, low, high, pps, even-second pulse, 10 MHz and periodic modes; the digital output lacks 10 MHz and periodic.
// - a mode write that names no output applies to every output.
// - a mode that an output does not support leaves that output unchanged.
// - invert flips every level of the output except off, and is only taken with a mode write.
// - the general width sets the pulse modes of both outputs, periodic uses its own width.
// - a signed delay in ns moves the coaxial second pulse, negative earlier, positive later.
// - the delay acts only on the coaxial pulse, never on the time base or the digital output.
// - a new delay is used from the very next emitted pulse without any restart.
// - second pulses are aligned to the UTC second mark of the time base.
// - the periodic period is accepted only from 2 to 100000 seconds.
// - the periodic pulse fires when the second count equals a value from 0 to period minus 1.
// - the periodic width is accepted only from 100 ns to 5E8 ns.
module tpo_top
   import tpo_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic        i_reset,
   input  wire logic        i_pps_utc,
   input  wire logic        i_sec_even,
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [31:0]      o_rdata,
   output logic             o_bnc,
   output logic             o_dig
);

   // ********************************************************
   // helpers
   // ********************************************************
   function automatic logic [16:0] sec_wrap(input logic [16:0] s, input logic [16:0] p);
      logic [16:0] n;
      n = s + 17'h1;
      return (n >= p) ? 17'h0 : n;
   endfunction

   function automatic logic width_ok(input logic [31:0] w);
      return (w >= {3'h0, WIDTH_MIN}) && (w <= {3'h0, WIDTH_MAX});
   endfunction

   function automatic logic out_level(input tpo_mode_t m, input logic inv,
                                      input logic pulse, input logic tenm);
      logic lv;
      lv = 1'b0;
      unique case (m)
         MODE_OFF:      lv = 1'b0;
         MODE_LOW:      lv = 1'b0;
         MODE_HIGH:     lv = 1'b1;
         MODE_TENM:     lv = tenm;
         MODE_PPS,
         MODE_EVEN,
         MODE_PERIODIC: lv = pulse;
      endcase
      // off stays quiet, every other level follows the invert flag
      return (m == MODE_OFF) ? 1'b0 : (lv ^ inv);
   endfunction

   // ********************************************************
   // state
   // ********************************************************
   tpo_mode_t          mode_bnc_r, mode_bnc_nxt;
   tpo_mode_t          mode_dig_r, mode_dig_nxt;
   logic               inv_bnc_r, inv_bnc_nxt;
   logic               inv_dig_r, inv_dig_nxt;
   logic [28:0]        width_r, width_nxt;
   logic signed [29:0] delay_r, delay_nxt;
   logic [16:0]        period_r, period_nxt;
   logic [16:0]        value_r, value_nxt;
   logic [28:0]        pwidth_r, pwidth_nxt;
   logic [16:0]        sec_r, sec_nxt;
   logic               even_r, even_nxt;
   logic               seen_r, seen_nxt;
   logic [30:0]        phase_r, phase_nxt;
   logic [3:0]         div_r, div_nxt;
   logic [31:0]        rdata_r, rdata_nxt;
   logic               bnc_r, bnc_nxt;
   logic               dig_r, dig_nxt;

   logic [30:0]        tgt_ns;
   logic               neg_dly;
   logic               tick_bnc;
   logic [16:0]        cnt_bnc;
   logic               even_bnc;
   logic               tenm_lv;
   logic [2:0]         wmode;
   logic [1:0]         wsel;
   logic [31:0]        wabs;

   tpo_pulse_if bnc_if ();
   tpo_pulse_if dig_if ();

   // ********************************************************
   // register writes
   // ********************************************************
   always_comb
   begin
      mode_bnc_nxt = mode_bnc_r;
      mode_dig_nxt = mode_dig_r;
      inv_bnc_nxt  = inv_bnc_r;
      inv_dig_nxt  = inv_dig_r;
      width_nxt    = width_r;
      delay_nxt    = delay_r;
      period_nxt   = period_r;
      value_nxt    = value_r;
      pwidth_nxt   = pwidth_r;
      wmode        = i_wdata[CTRL_MODE_LSB +: 3];
      wsel         = i_wdata[CTRL_SEL_LSB +: 2];
      wabs         = i_wdata[31] ? (32'h0 - i_wdata) : i_wdata;
      if (i_wr)
      begin
         unique case (i_addr)
            ADDR_CTRL:
            begin
               // code 7 names no mode; invert comes only with a valid mode
               if (wmode != 3'h7)
               begin
                  // coaxial output takes every mode
                  if (wsel == SEL_ALL || wsel == SEL_BNC)
                  begin
                     mode_bnc_nxt = tpo_mode_t'(wmode);
                     inv_bnc_nxt  = i_wdata[CTRL_INV_BIT];
                  end
                  // digital output has no 10 MHz or periodic drive
                  if ((wsel == SEL_ALL || wsel == SEL_DIG) && wmode <= MODE_EVEN)
                  begin
                     mode_dig_nxt = tpo_mode_t'(wmode);
                     inv_dig_nxt  = i_wdata[CTRL_INV_BIT];
                  end
               end
            end
            ADDR_WIDTH:
            begin
               if (width_ok(i_wdata))
               begin
                  width_nxt = i_wdata[28:0];
               end
            end
            ADDR_DELAY:
            begin
               // limited to half a second so the shifted pulse keeps its own second
               if (wabs <= {2'h0, DELAY_LIMIT})
               begin
                  delay_nxt = i_wdata[29:0];
               end
            end
            ADDR_PERIOD:
            begin
               if (i_wdata >= {15'h0, PERIOD_MIN} && i_wdata <= {15'h0, PERIOD_MAX}
                   && {15'h0, value_r} < i_wdata)
               begin
                  period_nxt = i_wdata[16:0];
               end
            end
            ADDR_VALUE:
            begin
               if (i_wdata < {15'h0, period_r})
               begin
                  value_nxt = i_wdata[16:0];
               end
            end
            ADDR_PWIDTH:
            begin
               if (width_ok(i_wdata))
               begin
                  pwidth_nxt = i_wdata[28:0];
               end
            end
            default:
            begin
            end
         endcase
      end
   end

   // ********************************************************
   // second tracking and delayed tick
   // ********************************************************
   always_comb
   begin
      sec_nxt   = sec_r;
      even_nxt  = even_r;
      seen_nxt  = seen_r;
      phase_nxt = phase_r;
      div_nxt   = div_r;
      if (i_pps_utc)
      begin
         sec_nxt   = sec_wrap(sec_r, period_r);
         even_nxt  = i_sec_even;
         seen_nxt  = 1'b1;
         phase_nxt = 31'h0;
         div_nxt   = 4'h0;
      end
      else
      begin
         // a lost time base freezes the phase rather than wrapping it
         if (phase_r < PHASE_MAX)
         begin
            phase_nxt = phase_r + NS_STEP;
         end
         div_nxt = (div_r == TENM_CYC - 4'h1) ? 4'h0 : div_r + 4'h1;
      end
   end

   // delay only moves where the coaxial tick falls; time base is untouched
   assign neg_dly  = delay_r[29];
   assign tgt_ns   = neg_dly ? (NS_SEC + {delay_r[29], delay_r}) : {1'b0, delay_r};
   // compared every cycle, so a fresh delay serves the next pulse
   assign tick_bnc = seen_r && !i_pps_utc && (phase_r <= tgt_ns)
                     && (tgt_ns < phase_r + NS_STEP);
   // an early pulse belongs to the second that is about to start
   assign cnt_bnc  = neg_dly ? sec_wrap(sec_r, period_r) : sec_r;
   assign even_bnc = neg_dly ? ~even_r : even_r;
   assign tenm_lv  = seen_r && (div_r < TENM_HIGH);

   // ********************************************************
   // pulse timers
   // ********************************************************
   always_comb
   begin
      unique case (mode_bnc_r)
         MODE_PPS:      bnc_if.start = tick_bnc;
         MODE_EVEN:     bnc_if.start = tick_bnc && even_bnc;
         MODE_PERIODIC: bnc_if.start = tick_bnc && (cnt_bnc == value_r);
         default:       bnc_if.start = 1'b0;
      endcase
      bnc_if.width_ns = (mode_bnc_r == MODE_PERIODIC) ? pwidth_r : width_r;
      unique case (mode_dig_r)
         MODE_PPS:  dig_if.start = i_pps_utc;
         MODE_EVEN: dig_if.start = i_pps_utc && i_sec_even;
         default:   dig_if.start = 1'b0;
      endcase
      dig_if.width_ns = width_r;
   end

   tpo_pulse u_bnc_pulse
   (
      .i_mclk  (i_mclk),
      .i_reset (i_reset),
      .pif     (bnc_if.gen)
   );

   tpo_pulse u_dig_pulse
   (
      .i_mclk  (i_mclk),
      .i_reset (i_reset),
      .pif     (dig_if.gen)
   );

   // ********************************************************
   // outputs and read data
   // ********************************************************
   always_comb
   begin
      bnc_nxt   = out_level(mode_bnc_r, inv_bnc_r, bnc_if.level, tenm_lv);
      dig_nxt   = out_level(mode_dig_r, inv_dig_r, dig_if.level, 1'b0);
      rdata_nxt = 32'h0;
      if (i_rd)
      begin
         unique case (i_addr)
            ADDR_CTRL:
            begin
               rdata_nxt[CTRL_MODE_LSB +: 3]              = mode_bnc_r;
               rdata_nxt[CTRL_INV_BIT]                    = inv_bnc_r;
               rdata_nxt[CTRL_DIG_LSB + CTRL_MODE_LSB +: 3] = mode_dig_r;
               rdata_nxt[CTRL_DIG_LSB + CTRL_INV_BIT]     = inv_dig_r;
            end
            ADDR_WIDTH:  rdata_nxt = {3'h0, width_r};
            ADDR_DELAY:  rdata_nxt = {{2{delay_r[29]}}, delay_r};
            ADDR_PERIOD: rdata_nxt = {15'h0, period_r};
            ADDR_VALUE:  rdata_nxt = {15'h0, value_r};
            ADDR_PWIDTH: rdata_nxt = {3'h0, pwidth_r};
            ADDR_STATUS:
            begin
               rdata_nxt[16:0]          = sec_r;
               rdata_nxt[STAT_EVEN_BIT] = even_r;
               rdata_nxt[STAT_SEEN_BIT] = seen_r;
            end
            default:     rdata_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
      begin
         mode_bnc_r <= MODE_OFF;
         mode_dig_r <= MODE_OFF;
         inv_bnc_r  <= 1'b0;
         inv_dig_r  <= 1'b0;
         width_r    <= WIDTH_RST;
         delay_r    <= 30'h0;
         period_r   <= PERIOD_RST;
         value_r    <= VALUE_RST;
         pwidth_r   <= WIDTH_RST;
         sec_r      <= 17'h0;
         even_r     <= 1'b0;
         seen_r     <= 1'b0;
         phase_r    <= 31'h0;
         div_r      <= 4'h0;
         rdata_r    <= 32'h0;
         bnc_r      <= 1'b0;
         dig_r      <= 1'b0;
      end
      else
      begin
         mode_bnc_r <= mode_bnc_nxt;
         mode_dig_r <= mode_dig_nxt;
         inv_bnc_r  <= inv_bnc_nxt;
         inv_dig_r  <= inv_dig_nxt;
         width_r    <= width_nxt;
         delay_r    <= delay_nxt;
         period_r   <= period_nxt;
         value_r    <= value_nxt;
         pwidth_r   <= pwidth_nxt;
         sec_r      <= sec_nxt;
         even_r     <= even_nxt;
         seen_r     <= seen_nxt;
         phase_r    <= phase_nxt;
         div_r      <= div_nxt;
         rdata_r    <= rdata_nxt;
         bnc_r      <= bnc_nxt;
         dig_r      <= dig_nxt;
      end
   end

   assign o_rdata = rdata_r;
   assign o_bnc   = bnc_r;
   assign o_dig   = dig_r;

endmodule

// *** rtl/tpo_pkg.sv ***
// constants and types shared by the timing pulse output design
package tpo_pkg;

   // ********************************************************
   // clock and time
   // ********************************************************
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned NS_PER_SEC    = 1000000000;
   localparam logic [30:0] NS_STEP       = 31'(CLK_PERIOD_NS);
   localparam logic [30:0] NS_SEC        = 31'(NS_PER_SEC);
   localparam logic [30:0] PHASE_MAX     = 31'h7FFF_FFF0;
   // 10 MHz: period and high time in clock cycles
   localparam int unsigned TENM_PERIOD_NS = 100;
   localparam logic [3:0]  TENM_CYC  = 4'(TENM_PERIOD_NS / CLK_PERIOD_NS);
   localparam logic [3:0]  TENM_HIGH = 4'(TENM_PERIOD_NS / CLK_PERIOD_NS / 2);

   // ********************************************************
   // register map (byte addresses)
   // ********************************************************
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_WIDTH   = 8'h04;
   localparam logic [7:0] ADDR_DELAY   = 8'h08;
   localparam logic [7:0] ADDR_PERIOD  = 8'h0C;
   localparam logic [7:0] ADDR_VALUE   = 8'h10;
   localparam logic [7:0] ADDR_PWIDTH  = 8'h14;
   localparam logic [7:0] ADDR_STATUS  = 8'h18;

   // ctrl write fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_INV_BIT  = 3;
   localparam int CTRL_SEL_LSB  = 4;
   // ctrl read layout: bnc at 0, digital at 4
   localparam int CTRL_DIG_LSB  = 4;
   // status fields
   localparam int STAT_EVEN_BIT = 17;
   localparam int STAT_SEEN_BIT = 18;

   localparam logic [1:0] SEL_ALL = 2'h0;
   localparam logic [1:0] SEL_BNC = 2'h1;
   localparam logic [1:0] SEL_DIG = 2'h2;

   // ********************************************************
   // ranges and reset values
   // ********************************************************
   localparam logic [28:0] WIDTH_MIN    = 29'd100;
   localparam logic [28:0] WIDTH_MAX    = 29'd500000000;
   localparam logic [28:0] WIDTH_RST    = 29'd100000000;
   localparam logic [16:0] PERIOD_MIN   = 17'd2;
   localparam logic [16:0] PERIOD_MAX   = 17'd100000;
   localparam logic [16:0] PERIOD_RST   = 17'd2;
   localparam logic [16:0] VALUE_RST    = 17'h0_0000;
   localparam logic [29:0] DELAY_LIMIT  = 30'd500000000;

   typedef enum logic [2:0] {
      MODE_OFF      = 3'h0,
      MODE_LOW      = 3'h1,
      MODE_HIGH     = 3'h2,
      MODE_PPS      = 3'h3,
      MODE_EVEN     = 3'h4,
      MODE_TENM     = 3'h5,
      MODE_PERIODIC = 3'h6
   } tpo_mode_t;

   typedef enum logic {
      PS_IDLE = 1'b0,
      PS_HIGH = 1'b1
   } tpo_pstate_t;

endpackage

// *** rtl/tpo_pulse_if.sv ***
// carrier between the output logic and a pulse width timer
`timescale 1ns/1ps
interface tpo_pulse_if;
   logic        start;
   logic [28:0] width_ns;
   logic        level;

   modport gen
   (
      input  start,
      input  width_ns,
      output level
   );
   modport user
   (
      output start,
      output width_ns,
      input  level
   );
endinterface

// *** rtl/tpo_pulse.sv ***
// pulse width timer: holds level high for width_ns after start
`timescale 1ns/1ps
module tpo_pulse
   import tpo_pkg::*;
(
   input  wire logic  i_mclk,
   input  wire logic  i_reset,
   tpo_pulse_if.gen   pif
);

   tpo_pstate_t state_r;
   tpo_pstate_t state_nxt;
   logic [28:0] ns_r;
   logic [28:0] ns_nxt;
   logic [28:0] wid_r;
   logic [28:0] wid_nxt;

   // ********************************************************
   // next state
   // ********************************************************
   always_comb
   begin
      state_nxt = state_r;
      ns_nxt    = ns_r;
      wid_nxt   = wid_r;
      // a new start restarts the width, so a retrigger never truncates
      if (pif.start)
      begin
         state_nxt = PS_HIGH;
         ns_nxt    = NS_STEP[28:0];
         wid_nxt   = pif.width_ns;
      end
      else
      begin
         unique case (state_r)
            PS_IDLE:
            begin
               ns_nxt = 29'h0;
            end
            PS_HIGH:
            begin
               if (ns_r >= wid_r)
               begin
                  state_nxt = PS_IDLE;
               end
               else
               begin
                  ns_nxt = ns_r + NS_STEP[28:0];
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
      begin
         state_r <= PS_IDLE;
         ns_r    <= 29'h0;
         wid_r   <= 29'h0;
      end
      else
      begin
         state_r <= state_nxt;
         ns_r    <= ns_nxt;
         wid_r   <= wid_nxt;
      end
   end

   assign pif.level = (state_r == PS_HIGH);

endmodule

// *** tb/tpo_top_sva.sv ***
// assertion checker on the timing pulse output ports
`timescale 1ns/1ps
module tpo_top_sva
   import tpo_pkg::*;
(
   input wire logic        i_mclk,
   input wire logic        i_reset,
   input wire logic        i_pps_utc,
   input wire logic        i_sec_even,
   input wire logic [7:0]  i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic        o_bnc,
   input wire logic        o_dig
);
   // ****************
   // shadow of modes and delay
   // ****************
   logic [2:0] bm_r;
   logic [2:0] dm_r;
   logic       bi_r;
   logic       di_r;
   logic       dz_r;
   wire  logic ctl = i_wr && (i_addr == ADDR_CTRL) && (i_wdata[2:0] != 3'h7);
   wire  logic tob = ctl && (i_wdata[5:4] < 2'h2);
   wire  logic tod = ctl && (i_wdata[5:4] != 2'h1) && (i_wdata[5:4] != 2'h3)
                     && (i_wdata[2:0] < 3'h5);
   wire  logic dok = i_wr && (i_addr == ADDR_DELAY) && ($signed(i_wdata) <= 32'sh1DCD6500)
                     && ($signed(i_wdata) >= -32'sh1DCD6500);

   // a single clocked block: the shadow is tiny, no split needed
   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
         {bm_r, bi_r, dm_r, di_r, dz_r} <= 9'h001;
      else
      begin
         if (tob)
            {bm_r, bi_r} <= {i_wdata[2:0], i_wdata[3]};
         if (tod)
            {dm_r, di_r} <= {i_wdata[2:0], i_wdata[3]};
         if (dok)
            dz_r <= (i_wdata == 32'h0);
      end
   end

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_reset);

   // ****************
   // assertions
   // ****************
   a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
      else $error("read data not zero outside read answer");
   a_unmapped_read: assert property (i_rd && (i_addr > ADDR_STATUS || i_addr[1:0] != 2'h0)
      |=> o_rdata == 32'h0) else $error("unmapped read not zero");
   a_ctrl_shadow: assert property (i_rd && i_addr == ADDR_CTRL |=>
      o_rdata[7:0] == {di_r, dm_r, bi_r, bm_r}) else $error("control readback wrong");
   a_dig_static: assert property (dm_r < 3'h3 && $stable(dm_r) && $stable(di_r) |->
      o_dig == ((dm_r != 3'h0) && ((dm_r == 3'h2) ^ di_r))) else $error("digital level wrong");
   a_bnc_static: assert property (bm_r < 3'h3 && $stable(bm_r) && $stable(bi_r) |->
      o_bnc == ((bm_r != 3'h0) && ((bm_r == 3'h2) ^ bi_r))) else $error("coax level wrong");
   a_dig_follow: assert property (i_pps_utc && dm_r == MODE_PPS && !di_r |-> ##2 o_dig)
      else $error("digital pulse missing after mark");
   a_dig_cause: assert property ($rose(o_dig) && (dm_r == MODE_PPS || dm_r == MODE_EVEN)
      && !di_r |-> $past(i_pps_utc, 2) && (dm_r == MODE_PPS || $past(i_sec_even, 2)))
      else $error("digital pulse without cause");
   a_bnc_tick: assert property (i_pps_utc && bm_r == MODE_PPS && !bi_r && dz_r
      |-> ##3 o_bnc) else $error("coax pulse missing after mark");
   a_pulse_min: assert property ($rose(o_dig) && dm_r == MODE_PPS && !di_r |-> o_dig[*8])
      else $error("digital pulse too short");
endmodule

// *** tb/tpo_far_end.sv ***
// far end equipment: stamps rising edges and measures high time
`timescale 1ns/1ps
module tpo_far_end
(
   input  wire logic i_mclk,
   input  wire logic i_line,
   output int        o_now,
   output int        o_rises,
   output int        o_rise_at,
   output int        o_high
);
   int   now_r = 0;
   int   rises_r = 0;
   int   rise_at_r = 0;
   int   high_r = 0;
   int   run = 0;
   logic prev = 1'b0;
   always @(posedge i_mclk)
   begin
      now_r <= now_r + 1;
      if (i_line && !prev)
      begin
         rises_r <= rises_r + 1;
         rise_at_r <= now_r + 1;
      end
      if (i_line)
         run <= run + 1;
      else if (prev)
      begin
         high_r <= run;
         run <= 0;
      end
      prev <= i_line;
   end
   assign o_now     = now_r;
   assign o_rises   = rises_r;
   assign o_rise_at = rise_at_r;
   assign o_high    = high_r;
endmodule

// *** tb/tb.sv ***
// self-checking bench for the timing pulse output
`timescale 1ns/1ps
module tb
   import tpo_pkg::*;
;
   logic        i_mclk = 1'b0;
   logic        i_reset = 1'b1;
   logic        i_pps_utc = 1'b0;
   logic        i_sec_even = 1'b0;
   logic [7:0]  i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic [31:0] o_rdata;
   logic        o_bnc;
   logic        o_dig;
   logic [31:0] rv;
   logic [3:0]  eb;
   logic [3:0]  ed;
   int          bad_count = 0;
   int          comparisons = 0;
   int          nb, nd, lb, ld, hb, hd, now, p, k, d, v, cnt, per;

   always #5 i_mclk = ~i_mclk;

   tpo_top dut_u (.i_mclk(i_mclk), .i_reset(i_reset), .i_pps_utc(i_pps_utc),
      .i_sec_even(i_sec_even), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .o_bnc(o_bnc), .o_dig(o_dig));
   tpo_far_end far_b (.i_mclk(i_mclk), .i_line(o_bnc), .o_now(), .o_rises(nb),
      .o_rise_at(lb), .o_high(hb));
   tpo_far_end far_d (.i_mclk(i_mclk), .i_line(o_dig), .o_now(now), .o_rises(nd),
      .o_rise_at(ld), .o_high(hd));

   // ****************
   // helpers
   // ****************
   function automatic logic lvl(input logic [3:0] c);
      return (c[2:0] != 3'h0) && ((c[2:0] == 3'h2) ^ c[3]);
   endfunction

   task automatic give_verdict();
      if (bad_count == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] x);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= x;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1;
      rv = o_rdata;
   endtask

   task automatic wrchk(input logic [7:0] a, input logic [31:0] x, input logic [31:0] exp);
      wr(a, x);
      rd(a);
      chk(rv, exp);
   endtask

   // one second mark, then room for the widest pulse to end
   task automatic mark(input logic e);
      @(posedge i_mclk);
      i_pps_utc <= 1'b1;
      i_sec_even <= e;
      @(posedge i_mclk);
      i_pps_utc <= 1'b0;
      #1;
      p = now;
      cnt = (cnt + 1) % per;
      repeat (58) @(posedge i_mclk);
   endtask

   initial
   begin
      #200000;
      bad_count++;
      give_verdict();
   end

   // ****************
   // main sequence
   // ****************
   initial
   begin
      k = $urandom(32'h2898);
      cnt = 0;
      per = 2;
      repeat (20) @(posedge i_mclk);
      i_reset <= 1'b0;
      mark(1'b0);
      rd(ADDR_WIDTH);
      chk(rv, 32'(WIDTH_RST));
      rd(ADDR_PWIDTH);
      chk(rv, 32'(WIDTH_RST));
      rd(ADDR_STATUS);
      chk(rv[18:0], 19'h40001);
      rd(8'h1C);
      chk(rv, 32'h0);
      wrchk(ADDR_PERIOD, 32'h186A1, 32'h2);
      wrchk(ADDR_PERIOD, 32'h1, 32'h2);
      wrchk(ADDR_PERIOD, 32'h186A0, 32'h186A0);
      for (k = 0; k < 4; k++)
      begin
         d = 2 + ($urandom % 99999);
         wrchk(ADDR_PERIOD, 32'(d), 32'(d));
      end
      v = $urandom % d;
      wrchk(ADDR_VALUE, 32'(v), 32'(v));
      wrchk(ADDR_VALUE, 32'(d), 32'(v));
      wrchk(ADDR_VALUE, 32'h1, 32'h1);
      wrchk(ADDR_PERIOD, 32'h3, 32'h3);
      per = 3;
      wrchk(ADDR_PWIDTH, 32'h63, 32'(WIDTH_RST));
      wrchk(ADDR_PWIDTH, 32'h1DCD6501, 32'(WIDTH_RST));
      wrchk(ADDR_PWIDTH, 32'h1DCD6500, 32'h1DCD6500);
      wrchk(ADDR_DELAY, 32'hFFFFFF38, 32'hFFFFFF38);
      wrchk(ADDR_DELAY, 32'h1DCD6501, 32'hFFFFFF38);
      wr(ADDR_DELAY, 32'h0);
      // every mode, polarity and target once, no marks meanwhile
      eb = 4'h0;
      ed = 4'h0;
      for (k = 0; k < 64; k++)
      begin
         wr(ADDR_CTRL, 32'(k));
         if (k[2:0] != 3'h7 && k[5:4] < 2'h2) eb = k[3:0];
         if (k[2:0] < 3'h5 && (k[5:4] == 2'h0 || k[5:4] == 2'h2)) ed = k[3:0];
         rd(ADDR_CTRL);
         chk(rv[7:0], {ed, eb});
         if (eb[2:0] != 3'h5) chk(32'(o_bnc), 32'(lvl(eb)));
         chk(32'(o_dig), 32'(lvl(ed)));
      end
      wr(ADDR_WIDTH, 32'hC8);
      wr(ADDR_CTRL, 32'h3);
      mark(1'b0);
      chk(32'(ld - p), 32'h2);
      chk(32'(lb - p), 32'h3);
      chk(32'(hd >= 20 && hd <= 22), 32'h1);
      chk(32'(hb >= 20 && hb <= 22), 32'h1);
      // delay changed between marks, each mark must use the new one
      for (k = 0; k < 3; k++)
      begin
         d = $urandom % 30;
         wr(ADDR_DELAY, 32'(d * 10));
         mark(1'b0);
         chk(32'(lb - p), 32'(d + 3));
         chk(32'(ld - p), 32'h2);
      end
      wr(ADDR_DELAY, 32'h0);
      wr(ADDR_CTRL, 32'h24);
      d = nd;
      mark(1'b0);
      chk(32'(nd - d), 32'h0);
      mark(1'b1);
      chk(32'(nd - d), 32'h1);
      wr(ADDR_PWIDTH, 32'h12C);
      wr(ADDR_CTRL, 32'h16);
      rd(ADDR_STATUS);
      chk(32'(rv[16:0]), 32'(cnt));
      for (k = 0; k < 6; k++)
      begin
         d = nb;
         mark(1'b0);
         chk(32'(nb - d), 32'(cnt == 1));
         if (cnt == 1) chk(32'(hb >= 30 && hb <= 32), 32'h1);
      end
      wr(ADDR_CTRL, 32'h15);
      mark(1'b0);
      d = nb;
      repeat (100) @(posedge i_mclk);
      chk(32'(nb - d), 32'hA);
      give_verdict();
   end
endmodule

bind tpo_top tpo_top_sva sva_u (.i_mclk, .i_reset, .i_pps_utc, .i_sec_even, .i_addr,
   .i_wdata, .i_wr, .i_rd, .o_rdata, .o_bnc, .o_dig);
